/* File: inc/adsc_map.svh */
// Offsets, field positions, command codes and timing counts of the
// converter serial block. Included by the register and top design files and the bench.
`ifndef ADSC_MAP_SVH
`define ADSC_MAP_SVH
`define ADSC_CMD_RESET   7'h03
`define ADSC_CMD_START   7'h04
`define ADSC_CMD_SLEEP   7'h01
`define ADSC_CMD_FETCH   4'h1
`define ADSC_CMD_REG_READ_CMD    4'h2
`define ADSC_CMD_REG_WRITE_CMD    4'h4
`define ADSC_RAW_MAX     20'sh07fff
`define ADSC_RAW_MIN     20'shf8000
`define ADSC_RES_MAX     16'h7fff
`define ADSC_RES_MIN     16'h8000
`define ADSC_CFG_RST     32'h0000_0000
`define ADSC_CM_BIT      10
`define ADSC_MODE_LO     11
`define ADSC_MODE_HI     12
`define ADSC_PSW_BIT     19
`define ADSC_READY_ON_OUT_SEL_BIT   25
`define ADSC_RES_BITS    5'h10
`define ADSC_TRAIL       5'h10
`define ADSC_TRAIL_LOW   5'h08
`define ADSC_RD_WAIT     2'h2
`define ADSC_CLK_NS      10
`define ADSC_TMOD_NS     3906
`define ADSC_MOD_CYC     (`ADSC_TMOD_NS / `ADSC_CLK_NS)
`define ADSC_TOUT_NORM   13955
`define ADSC_TOUT_TURBO  27910
`define ADSC_PULSE_MODS  2
`define ADSC_PULSE_CYC   (`ADSC_PULSE_MODS * `ADSC_MOD_CYC)
`endif

/* File: inc/adsc_pkg.sv */
// Types of the converter serial block: commands, link states, state records.
// Assumes adsc_map.svh sits on the include path.
package adsc_pkg;
  typedef enum logic [2:0] {
    adsc_c_none  = 3'b000,
    adsc_c_reset = 3'b001,
    adsc_c_start = 3'b010,
    adsc_c_sleep = 3'b011,
    adsc_c_fetch = 3'b100,
    adsc_c_reg_read_cmd  = 3'b101,
    adsc_c_reg_write_cmd  = 3'b110
  } adsc_cmd_t;
  typedef enum logic [1:0] {
    adsc_s_cmd   = 2'b00,
    adsc_s_fetch = 2'b01,
    adsc_s_reg_read_cmd  = 2'b10,
    adsc_s_reg_write_cmd  = 2'b11
  } adsc_link_t;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic       sclk_d;
  } adsc_sync_t;
  typedef struct packed {
    logic [31:0] cfg;
    logic [7:0]  rdata;
  } adsc_regs_t;
  typedef struct packed {
    adsc_link_t  st;
    logic [2:0]  bit_cnt;
    logic [7:0]  in_sr;
    logic [15:0] out_sr;
    logic [4:0]  out_cnt;
    logic        is_res;
    logic [4:0]  trail;
    logic [1:0]  left;
    logic [1:0]  idx;
    logic [1:0]  load_pend;
    logic [31:0] stage;
    logic [3:0]  mask;
    logic [3:0]  wbe;
    logic        clr;
    logic [15:0] snap;
    logic [15:0] res;
    logic        newer;
    logic        rdy_n;
    logic [9:0]  pcnt;
    logic        dout;
    logic        sleep;
    logic        sleep_pend;
    logic        run;
    logic        restart;
    logic [23:0] tout;
  } adsc_state_t;
endpackage

/* File: inc/adsc_reg_if.sv */
// Carrier between the command engine and the configuration store.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface adsc_reg_if;
  logic        clr;
  logic [3:0]  wbe;
  logic [31:0] wdata;
  logic [1:0]  raddr;
  logic [7:0]  rdata;
  logic [31:0] cfg;
  modport ctl (output clr, wbe, wdata, raddr, input rdata, cfg);
  modport mem (input clr, wbe, wdata, raddr, output rdata, cfg);
endinterface

/* File: src/adsc_sync.sv */
// Two-stage synchronisers for the serial pins and serial clock edge finder.
// Assumes pins are asynchronous to clk_in and much slower than it.
`timescale 1ns/100ps
module adsc_sync (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic sclk_in,
  input  wire logic cs_b_in,
  input  wire logic din_in,
  output logic      rise_out,
  output logic      fall_out,
  output logic      cs_b_out,
  output logic      din_out
);
  adsc_pkg::adsc_sync_t q, d;

  always_comb begin
    d = q;
    d.s1 = {din_in, cs_b_in, sclk_in};
    d.s2 = q.s1;
    d.sclk_d = q.s2[0];
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.s1[1] <= 1'b1;
      q.s2[1] <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rise_out = q.s2[0] & ~q.sclk_d;
  assign fall_out = ~q.s2[0] & q.sclk_d;
  assign cs_b_out = q.s2[1];
  assign din_out  = q.s2[2];
endmodule // adsc_sync

/* File: src/adsc_regs.sv */
// Four byte-wide configuration registers with a registered read port.
// Assumes clear and byte writes come from the command engine.
`timescale 1ns/100ps
`include "adsc_map.svh"
module adsc_regs (
  input wire logic clk_in,
  input wire logic rst_b_in,
  adsc_reg_if.mem  bus
);
  adsc_pkg::adsc_regs_t q, d;

  always_comb begin
    d = q;
    for (int i = 0; i < 4; i++) begin
      if (bus.wbe[i]) begin
        d.cfg[i*8 +: 8] = bus.wdata[i*8 +: 8];
      end
    end
    // Clear wins: a reset command must never leave a stale byte behind
    if (bus.clr) begin
      d.cfg = `ADSC_CFG_RST;
    end
    d.rdata = q.cfg[{bus.raddr, 3'b000} +: 8];
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.rdata = q.rdata;
  assign bus.cfg   = q.cfg;
endmodule // adsc_regs

/* File: src/adsc_top.sv */
// Serial command decoder and result readout of a 16-bit converter.
// Assumes conv_done_in, conv_busy_in and raw_in come from the filter on clk_in.
`timescale 1ns/100ps
`include "adsc_map.svh"
module adsc_top #(
  parameter int TOUT_NORM_CYC  = `ADSC_TOUT_NORM * `ADSC_MOD_CYC,
  parameter int TOUT_TURBO_CYC = `ADSC_TOUT_TURBO * (`ADSC_MOD_CYC / 2)
) (
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               sclk_in,
  input  wire logic               cs_b_in,
  input  wire logic               din_in,
  input  wire logic               conv_done_in,
  input  wire logic               conv_busy_in,
  input  wire logic signed [19:0] raw_in,
  output logic                    ready_flag_n_out,
  output logic                    shared_out_ready_out,
  output logic                    shared_out_ready_oe_b_out,
  output logic                    conv_restart_out,
  output logic                    continuous_select_out,
  output logic                    analog_on_out,
  output logic                    low_switch_closed_out,
  output logic [31:0]             config_out
);
  adsc_pkg::adsc_state_t q, d;
  adsc_pkg::adsc_cmd_t   cmd;
  logic       rise_s, fall_s, cs_b_s, din_s;
  logic       rise, fall, tmo, sel, shown;
  logic [7:0] b;
  logic [3:0] m;

  adsc_reg_if rif ();

  adsc_sync u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .sclk_in  (sclk_in),
    .cs_b_in  (cs_b_in),
    .din_in   (din_in),
    .rise_out (rise_s),
    .fall_out (fall_s),
    .cs_b_out (cs_b_s),
    .din_out  (din_s)
  );

  adsc_regs u_regs (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .bus      (rif)
  );

  function automatic logic [15:0] clip(input logic signed [19:0] v);
    if (v > `ADSC_RAW_MAX) begin
      clip = `ADSC_RES_MAX;
    end else if (v < `ADSC_RAW_MIN) begin
      clip = `ADSC_RES_MIN;
    end else begin
      clip = v[15:0];
    end
  endfunction

  function automatic adsc_pkg::adsc_cmd_t decode(input logic [7:0] v);
    if (v[7:1] == `ADSC_CMD_RESET) begin
      decode = adsc_pkg::adsc_c_reset;
    end else if (v[7:1] == `ADSC_CMD_START) begin
      decode = adsc_pkg::adsc_c_start;
    end else if (v[7:1] == `ADSC_CMD_SLEEP) begin
      decode = adsc_pkg::adsc_c_sleep;
    end else if (v[7:4] == `ADSC_CMD_FETCH) begin
      decode = adsc_pkg::adsc_c_fetch;
    end else if (v[7:4] == `ADSC_CMD_REG_READ_CMD) begin
      decode = adsc_pkg::adsc_c_reg_read_cmd;
    end else if (v[7:4] == `ADSC_CMD_REG_WRITE_CMD) begin
      decode = adsc_pkg::adsc_c_reg_write_cmd;
    end else begin
      decode = adsc_pkg::adsc_c_none;
    end
  endfunction

  assign sel   = rif.cfg[`ADSC_READY_ON_OUT_SEL_BIT];
  assign rise  = rise_s & ~cs_b_s;
  assign fall  = fall_s & ~cs_b_s;
  assign b     = {q.in_sr[6:0], din_s};
  assign cmd   = decode(b);
  // Turbo halves the modulator period, so its limit is a separate count
  assign tmo   = (rif.cfg[`ADSC_MODE_HI] & ~rif.cfg[`ADSC_MODE_LO]) ?
                 (q.tout >= 24'(TOUT_TURBO_CYC)) :
                 (q.tout >= 24'(TOUT_NORM_CYC));
  assign shown = (q.out_cnt == 5'h00) ||
                 (q.is_res && q.out_cnt == `ADSC_RES_BITS);

  always_comb begin
    d = q;
    m = q.mask;
    d.restart = 1'b0;
    d.clr = 1'b0;
    d.wbe = 4'h0;
    if (q.pcnt != 10'h000) begin
      d.pcnt = q.pcnt - 10'h001;
      if (q.pcnt == 10'h001) begin
        d.rdy_n = 1'b0;
      end
    end
    if (cs_b_s || tmo) begin
      d.st = adsc_pkg::adsc_s_cmd;
      d.bit_cnt = 3'h0;
      d.trail = 5'h00;
      d.tout = 24'h000000;
      d.load_pend = 2'h0;
      if (q.st != adsc_pkg::adsc_s_cmd) begin
        d.out_cnt = 5'h00;
      end
    end else begin
      if (q.st != adsc_pkg::adsc_s_cmd || q.bit_cnt != 3'h0) begin
        d.tout = q.tout + 24'h000001;
      end else begin
        d.tout = 24'h000000;
      end
      if (rise) begin
        if (!q.newer) begin
          d.rdy_n = 1'b1;
        end
        if (q.out_cnt != 5'h00) begin
          d.dout = q.out_sr[15];
          d.out_sr = {q.out_sr[14:0], 1'b0};
          d.out_cnt = q.out_cnt - 5'h01;
          if (q.out_cnt == 5'h01 && q.is_res) begin
            d.trail = `ADSC_TRAIL;
          end
        end else if (q.trail != 5'h00) begin
          d.dout = (q.trail > `ADSC_TRAIL_LOW) ? 1'b0 : 1'b1;
          d.trail = q.trail - 5'h01;
        end
      end
      if (fall) begin
        d.in_sr = b;
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == 3'h0 && q.st == adsc_pkg::adsc_s_cmd) begin
          d.snap = q.res;
          d.newer = 1'b0;
        end
        if (q.bit_cnt == 3'h7) begin
          d.tout = 24'h000000;
          unique case (q.st)
            adsc_pkg::adsc_s_cmd: begin
              unique case (cmd)
                adsc_pkg::adsc_c_reset: begin
                  d.clr = 1'b1;
                  d.run = 1'b0;
                  d.sleep = 1'b0;
                  d.sleep_pend = 1'b0;
                end
                adsc_pkg::adsc_c_start: begin
                  d.restart = 1'b1;
                  d.run = 1'b1;
                  d.sleep = 1'b0;
                  d.sleep_pend = 1'b0;
                end
                adsc_pkg::adsc_c_sleep: begin
                  d.sleep_pend = 1'b1;
                end
                adsc_pkg::adsc_c_fetch: begin
                  d.st = adsc_pkg::adsc_s_fetch;
                  d.out_sr = q.snap;
                  d.out_cnt = `ADSC_RES_BITS;
                  d.is_res = 1'b1;
                  d.trail = 5'h00;
                  d.left = 2'h1;
                end
                adsc_pkg::adsc_c_reg_read_cmd: begin
                  d.st = adsc_pkg::adsc_s_reg_read_cmd;
                  d.idx = b[3:2];
                  d.left = b[1:0];
                  d.out_cnt = 5'h00;
                  d.trail = 5'h00;
                  d.load_pend = `ADSC_RD_WAIT;
                end
                adsc_pkg::adsc_c_reg_write_cmd: begin
                  d.st = adsc_pkg::adsc_s_reg_write_cmd;
                  d.idx = b[3:2];
                  d.left = b[1:0];
                  d.mask = 4'h0;
                end
                default: begin
                end
              endcase
            end
            adsc_pkg::adsc_s_fetch, adsc_pkg::adsc_s_reg_read_cmd: begin
              // Bytes here are data clocks, never commands
              if (q.left == 2'h0) begin
                d.st = adsc_pkg::adsc_s_cmd;
              end else begin
                d.left = q.left - 2'h1;
                if (q.st == adsc_pkg::adsc_s_reg_read_cmd) begin
                  d.idx = q.idx + 2'h1;
                  d.load_pend = `ADSC_RD_WAIT;
                end
              end
            end
            adsc_pkg::adsc_s_reg_write_cmd: begin
              d.stage[{q.idx, 3'b000} +: 8] = b;
              m[q.idx] = 1'b1;
              d.mask = m;
              d.idx = q.idx + 2'h1;
              if (q.left == 2'h0) begin
                d.wbe = m;
                d.restart = 1'b1;
                d.run = 1'b1;
                d.sleep = 1'b0;
                d.sleep_pend = 1'b0;
                d.st = adsc_pkg::adsc_s_cmd;
              end else begin
                d.left = q.left - 2'h1;
              end
            end
          endcase
        end
      end
      // Read port is registered, so the byte is taken two cycles later
      if (q.load_pend != 2'h0 && !rise && !fall) begin
        d.load_pend = q.load_pend - 2'h1;
        if (q.load_pend == 2'h1) begin
          d.out_sr = {rif.rdata, 8'h00};
          d.out_cnt = 5'h08;
          d.is_res = 1'b0;
        end
      end
    end
    if (q.sleep_pend && !conv_busy_in) begin
      d.sleep = 1'b1;
      d.sleep_pend = 1'b0;
    end
    if (conv_done_in) begin
      d.res = clip(raw_in);
      d.newer = 1'b1;
      if (!q.rdy_n && q.pcnt == 10'h000) begin
        d.rdy_n = 1'b1;
        d.pcnt = 10'(`ADSC_PULSE_CYC);
      end else begin
        d.rdy_n = 1'b0;
      end
      // A plain read already under way keeps its word intact
      if (d.st == adsc_pkg::adsc_s_cmd && shown && d.load_pend == 2'h0) begin
        d.out_sr = clip(raw_in);
        d.out_cnt = `ADSC_RES_BITS;
        d.is_res = 1'b1;
        d.newer = 1'b0;
      end
    end
    if (sel && !rise && q.st == adsc_pkg::adsc_s_cmd && shown &&
        q.trail == 5'h00) begin
      d.dout = d.rdy_n;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.rdy_n <= 1'b1;
      q.dout <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rif.clr   = q.clr;
  assign rif.wbe   = q.wbe;
  assign rif.wdata = q.stage;
  assign rif.raddr = q.idx;

  assign ready_flag_n_out          = q.rdy_n;
  assign shared_out_ready_out      = q.dout;
  assign shared_out_ready_oe_b_out = cs_b_s;
  assign conv_restart_out          = q.restart;
  assign continuous_select_out     = rif.cfg[`ADSC_CM_BIT];
  assign analog_on_out             = ~q.sleep;
  assign low_switch_closed_out     = rif.cfg[`ADSC_PSW_BIT] & q.run &
                                     ~q.sleep;
  assign config_out                = rif.cfg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_clip;
    conv_done_in && raw_in > `ADSC_RAW_MAX |=> q.res == `ADSC_RES_MAX;
  endproperty
  a_clip: assert property (p_clip)
    else $error("positive overrange not clipped");

  property p_start;
    fall && q.bit_cnt == 3'h7 && q.st == adsc_pkg::adsc_s_cmd &&
    cmd == adsc_pkg::adsc_c_start |=> conv_restart_out ##1 !conv_restart_out;
  endproperty
  a_start: assert property (p_start)
    else $error("start byte gave no single restart pulse");

  property p_fetch;
    fall && q.bit_cnt == 3'h7 && q.st == adsc_pkg::adsc_s_cmd &&
    cmd == adsc_pkg::adsc_c_fetch
    |=> q.out_cnt == `ADSC_RES_BITS && q.out_sr == $past(q.snap);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch did not load the snapshot");

  property p_cs_reset;
    cs_b_s |=> q.st == adsc_pkg::adsc_s_cmd && q.bit_cnt == 3'h0;
  endproperty
  a_cs_reset: assert property (p_cs_reset)
    else $error("link state kept while deselected");

  property p_msb;
    rise && q.out_cnt != 5'h00 |=> shared_out_ready_out == $past(q.out_sr[15]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("wrong bit shifted out");

  property p_trail;
    rise && q.out_cnt == 5'h00 && q.trail > `ADSC_TRAIL_LOW
    |=> !shared_out_ready_out;
  endproperty
  a_trail: assert property (p_trail)
    else $error("shared pin not low in first trailing clocks");

  property p_sleep_wait;
    q.sleep_pend && conv_busy_in && !q.sleep |=> !q.sleep;
  endproperty
  a_sleep_wait: assert property (p_sleep_wait)
    else $error("sleep entered during a conversion");

  property p_no_decode;
    q.st == adsc_pkg::adsc_s_fetch && fall && q.bit_cnt == 3'h7 &&
    q.left == 2'h0 |=> q.st == adsc_pkg::adsc_s_cmd && !conv_restart_out;
  endproperty
  a_no_decode: assert property (p_no_decode)
    else $error("fetch did not end cleanly");

  property p_pulse;
    conv_done_in && !q.rdy_n && q.pcnt == 10'h000 |=> q.rdy_n [*2];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("unread result gave no high pulse");

  property p_reg_write_cmd;
    fall && q.bit_cnt == 3'h7 && q.st == adsc_pkg::adsc_s_reg_write_cmd &&
    q.left == 2'h0 |=> conv_restart_out && rif.wbe != 4'h0;
  endproperty
  a_reg_write_cmd: assert property (p_reg_write_cmd)
    else $error("write completion did not apply and restart");

  c_fetch: cover property (q.st == adsc_pkg::adsc_s_fetch);
  c_reg_read_cmd: cover property (q.st == adsc_pkg::adsc_s_reg_read_cmd && q.load_pend == 2'h1);
  c_reg_write_cmd: cover property (rif.wbe != 4'h0);
  c_trail: cover property (q.trail == 5'h01 && rise);
endmodule // adsc_top

/* File: testbench/adsc_host_model.sv */
// Host side of the serial link: a mode 1 master with select and data input.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
module adsc_host_model (
  output logic      sclk_out,
  output logic      cs_b_out,
  output logic      din_out,
  input  wire logic dout_in,
  input  wire logic dout_oe_b_in
);
  initial begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    din_out  = 1'b0;
  end
  // Clock stands low between frames
  task automatic sel(input logic on);
    cs_b_out = ~on;
    // A deselected input shows no stale level
    if (!on) din_out = ~din_out;
    #80;
  endtask
  // Data changes on the rise, both ends sample on the fall, MSB first
  task automatic xfer(input logic [7:0] tx, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sclk_out = ~sclk_out;
      din_out  = tx[i];
      #80;
      sclk_out = ~sclk_out;
      rx[i]    = dout_oe_b_in ? 1'bx : dout_in;
      #80;
    end
  endtask
endmodule // adsc_host_model

/* File: testbench/test_adc_serial_command_and_readout.sv */
// Self-checking bench of the converter serial block against a bench model.
// Assumes the host model drives the serial pins at 160 ns per bit.
`timescale 1ns/100ps
`include "adsc_map.svh"
module test_adc_serial_command_and_readout;
  logic               clk, rst_b, done, busy;
  logic signed [19:0] raw;
  logic               sclk, cs_b, din, flag_n, sh, sh_oe_b, restart;
  logic               cont, ana, sw;
  logic [31:0]        cfg;
  logic [7:0]         rx, ct [4];
  int                 n_fail, checked, n_rst, n0, cfg_m [4], tv [8];
  adsc_top #(.TOUT_NORM_CYC(200), .TOUT_TURBO_CYC(150)) i_dut (
    .clk_in(clk), .rst_b_in(rst_b), .sclk_in(sclk), .cs_b_in(cs_b),
    .din_in(din), .conv_done_in(done), .conv_busy_in(busy), .raw_in(raw),
    .ready_flag_n_out(flag_n), .shared_out_ready_out(sh),
    .shared_out_ready_oe_b_out(sh_oe_b), .conv_restart_out(restart),
    .continuous_select_out(cont), .analog_on_out(ana),
    .low_switch_closed_out(sw), .config_out(cfg));
  adsc_host_model i_host (.sclk_out(sclk), .cs_b_out(cs_b), .din_out(din),
    .dout_in(sh), .dout_oe_b_in(sh_oe_b));
  function automatic logic [15:0] clip(input int v);
    if (v > 32767) return 16'h7fff;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction
  function automatic logic [31:0] cfgv();
    return {cfg_m[3][7:0], cfg_m[2][7:0], cfg_m[1][7:0], cfg_m[0][7:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xb(input logic [7:0] tx, input int nb = 8);
    i_host.xfer(tx, nb, rx);
  endtask
  task automatic conv(input int v);
    cyc(1);
    raw  = 20'(v);
    done = 1'b1;
    cyc(1);
    done = 1'b0;
  endtask
  // Result read with input low, then sixteen idle clocks when fl is set
  task automatic rd_res(input logic [15:0] e, input logic [7:0] c,
                        input logic fl);
    if (c != 8'h00) xb(c);
    xb(8'h00);
    chk(rx, e[15:8]);
    xb(8'h00);
    chk(rx, e[7:0]);
    cyc(2);
    chk(flag_n, fl);
    if (fl) begin
      xb(8'h00);
      chk(rx, 8'h00);
      xb(8'h00);
      chk(rx, 8'hff);
    end
  endtask
  always @(posedge clk) if (restart === 1'b1) n_rst++;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1_000_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    rst_b = 1'b0;
    done  = 1'b0;
    busy  = 1'b0;
    raw   = '0;
    void'($urandom(11896));
    cyc(4);
    chk(cfg, 32'h0);
    chk(sh_oe_b, 1'b1);
    rst_b = 1'b1;
    cyc(4);
    i_host.sel(1'b1);
    // Mode is normal or turbo: both shortened limits outlast one byte
    cfg_m = '{$urandom_range(255, 1), $urandom_range(255, 0) & 'hf7,
              $urandom_range(255, 0), $urandom_range(255, 0) | 'h02};
    n0 = n_rst;
    xb(8'h43);
    for (int i = 0; i < 4; i++) xb(cfg_m[i][7:0]);
    cyc(2);
    chk(cfg, cfgv());
    chk(cont, cfg_m[1][2]);
    chk(n_rst - n0, 1);
    xb(8'h26);
    for (int i = 1; i < 4; i++) begin
      xb(8'h00);
      chk(rx, cfg_m[i][7:0]);
    end
    ct = '{8'h08, 8'h03, 8'h09, 8'h02};
    for (int i = 0; i < 4; i++) begin
      busy = 1'b1;
      n0 = n_rst;
      xb(ct[i]);
      cyc(2);
      chk(ana, 1'b1);
      chk(n_rst - n0, !i[0]);
      busy = 1'b0;
      cyc(3);
      chk(ana, !i[0]);
      chk(sw, !i[0] & cfg_m[2][3]);
    end
    n0 = n_rst;
    ct = '{8'hff, 8'h30, 8'h0a, 8'h50};
    for (int i = 0; i < 4; i++) begin
      busy = 1'($urandom_range(1, 0));
      xb(ct[i]);
      cyc(2);
      chk(cfg, cfgv());
      chk(n_rst - n0, 0);
    end
    tv = '{0, 1, -1, 32767, -32768, 40000, -40000, 0};
    tv[7] = $urandom_range(32'hfffff, 0) - 32'h80000;
    for (int i = 0; i < 8; i++) begin
      conv(tv[i]);
      cyc(2);
      chk(flag_n, 1'b0);
      chk(sh, 1'b0);
      rd_res(clip(tv[i]), i[0] ? 8'h10 : 8'h00, 1'b1);
    end
    conv(100);
    fork
      begin
        #400;
        conv(200);
      end
    join_none
    rd_res(clip(100), 8'h10, 1'b0);
    rd_res(clip(200), 8'h10, 1'b1);
    conv(-5);
    cyc(2);
    i_host.sel(1'b0);
    chk(sh_oe_b, 1'b1);
    chk(flag_n, 1'b0);
    i_host.sel(1'b1);
    chk(sh_oe_b, 1'b0);
    chk(sh, 1'b0);
    rd_res(clip(-5), 8'h00, 1'b1);
    // Two results with no read between: flag pulses high, then drops
    conv(7);
    cyc(2);
    conv(9);
    cyc(2);
    chk(flag_n, 1'b1);
    cyc(`ADSC_PULSE_CYC);
    chk(flag_n, 1'b0);
    rd_res(clip(9), 8'h00, 1'b1);
    // Register write sent inside a plain read leaves the read intact
    conv(-300);
    cyc(2);
    n0 = n_rst;
    cfg_m[2] = $urandom_range(255, 0);
    xb(8'h48);
    chk(rx, 8'hfe);
    xb(cfg_m[2][7:0]);
    chk(rx, 8'hd4);
    cyc(2);
    chk(n_rst - n0, 1);
    chk(cfg, cfgv());
    xb(8'h00);
    chk(rx, 8'h00);
    xb(8'h00);
    chk(rx, 8'hff);
    // A broken command must not shift later bytes out of alignment
    for (int k = 0; k < 2; k++) begin
      xb(8'h20, 3);
      if (k == 0) #3000;
      else begin
        i_host.sel(1'b0);
        i_host.sel(1'b1);
      end
      xb(8'h20);
      xb(8'h00);
      chk(rx, cfg_m[0][7:0]);
    end
    xb(8'h06);
    #50000;
    cyc(32);
    chk(cfg, 32'h0);
    chk(cont, 1'b0);
    tally_and_finish();
  end
endmodule // test_adc_serial_command_and_readout
